// ==== design/mcsu_defines.svh ====
/*
 * Offsets, field positions and reset values of the memory chip-select unit.
 * Assumes it is included by bare name into the unit's module and the bench.
 */
`ifndef MCSU_DEFINES_SVH
`define MCSU_DEFINES_SVH

// ==========================================================================
// Register indices; the byte address on the bus is four times the index.
`define MCSU_IDX_UPPER 8'ha0
`define MCSU_IDX_LOW 8'ha2
`define MCSU_IDX_PERIPH 8'ha4
`define MCSU_IDX_STATUS 8'hac
`define MCSU_IDX_REFRESH 8'he4

// ==========================================================================
// Reset values.
`define MCSU_UPPER_RST 16'hf03b
`define MCSU_LOW_RST 16'h0000
`define MCSU_PERIPH_RST 16'h0000
`define MCSU_REFRESH_RST 16'h0000

// ==========================================================================
// Field positions.
`define MCSU_LIM_HI 14
`define MCSU_LIM_LO 12
`define MCSU_DA_BIT 7
`define MCSU_PSE_BIT 6
`define MCSU_RDY_BIT 2
`define MCSU_WAIT_HI 1
`define MCSU_WAIT_LO 0
`define MCSU_PWAIT3_BIT 3
`define MCSU_PBASE_HI 15
`define MCSU_PBASE_LO 7
`define MCSU_REFRESH_EN_BIT 15

// ==========================================================================
// Strap capture delay after reset release, in clock cycles.
`define MCSU_STRAP_DELAY 2'h3

`endif

// ==== design/mcsu_pkg.sv ====
/*
 * Types of the memory chip-select unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mcsu_pkg;

    // ======================================================================
    // Cycle state machine, Gray coded along idle, wait, done.
    typedef enum logic [1:0] {
        MCSU_IDLE = 2'h0,
        MCSU_WAIT = 2'h1,
        MCSU_DONE = 2'h3
    } mcsu_state_t;

    // ======================================================================
    // Bus cycle request from the bus interface unit.
    typedef struct packed {
        logic valid;
        logic mem;
        logic [19:0] addr;
    } mcsu_cyc_t;

    // ======================================================================
    // Select outputs, all active low.
    typedef struct packed {
        logic upper_n;
        logic low_n;
        logic [3:0] periph_n;
    } mcsu_sel_t;

endpackage

// ==== design/mcsu_top.sv ====
/*
 * Memory chip-select unit: register file on Avalon-MM, address decode of
 * upper, low and peripheral selects, wait-state and ready sequencing.
 * Assumes the bus interface unit presents one cycle at a time and waits for
 * cyc_done; ext_ready and the strap pin arrive asynchronously.
 */
// Operation
// - Peripheral wait code maps to 0..15 waits
// - Low select off until its register written
// - Low region top set by limit code
// - Low region always starts at zero
// - Address-drive-off bit stops driving the address
// - Strap low forces address drive always
// - Pseudo-static enable bit marks low space
// - Refresh enable turns shared pin into strobe
// - Ready-mode zero waits for external ready
// - Two-bit field gives 0..3 wait states
// - Upper select resets active, F03Bh
// - Upper region ends at top, bottom programmable
// - Peripheral bit3 high wait, bit2 ready
// - Four 256-byte peripheral ranges above base
`timescale 1ns/10ps
`include "mcsu_defines.svh"

module mcsu_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire mcsu_pkg::mcsu_cyc_t cyc_req,
    output logic cyc_done,
    input wire logic ext_ready,
    input wire logic addr_enable_strap_n,
    input wire logic midrange_select_three_n,
    input wire logic refresh_strobe_n,
    output mcsu_pkg::mcsu_sel_t sel,
    output logic addr_drive_en,
    output logic pseudo_static_enable,
    output logic shared_pin_n
);

    // ======================================================================
    // Input synchronisers.
    logic ready_meta, ready_sync, strap_meta, strap_sync;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ready_meta <= 1'b0;
            ready_sync <= 1'b0;
            strap_meta <= 1'b1;
            strap_sync <= 1'b1;
        end else begin
            ready_meta <= ext_ready;
            ready_sync <= ready_meta;
            strap_meta <= addr_enable_strap_n;
            strap_sync <= strap_meta;
        end
    end

    // ======================================================================
    // Register file and strap capture.
    logic [15:0] upper_region_select_cfg, low_region_select_cfg, periph_cfg, refresh_enable_reg;
    logic low_en, periph_en, strap_forced, strap_taken;
    logic [1:0] strap_cnt;
    logic [15:0] next_upper, next_low, next_periph, next_refresh;
    logic next_low_en, next_periph_en, next_strap_forced, next_strap_taken;
    logic [1:0] next_strap_cnt;
    logic ack, next_ack;
    logic [31:0] next_readdata;
    logic [15:0] status;
    logic take_wr;
    mcsu_pkg::mcsu_state_t state;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    always_comb begin
        next_ack = (avs_read | avs_write) & ~ack;
        take_wr = avs_write & ~ack;
        next_upper = upper_region_select_cfg;
        next_low = low_region_select_cfg;
        next_periph = periph_cfg;
        next_refresh = refresh_enable_reg;
        next_low_en = low_en;
        next_periph_en = periph_en;
        next_readdata = 32'h0;
        status = {12'h0, strap_forced, periph_en, low_en, state != mcsu_pkg::MCSU_IDLE};
        if (take_wr) begin
            case (avs_address)
                {`MCSU_IDX_UPPER, 2'h0}: begin
                    next_upper = merge(upper_region_select_cfg, avs_writedata, avs_byteenable);
                end
                {`MCSU_IDX_LOW, 2'h0}: begin
                    // Any write at all activates the low select.
                    next_low = merge(low_region_select_cfg, avs_writedata, avs_byteenable);
                    next_low_en = 1'b1;
                end
                {`MCSU_IDX_PERIPH, 2'h0}: begin
                    next_periph = merge(periph_cfg, avs_writedata, avs_byteenable);
                    next_periph_en = 1'b1;
                end
                {`MCSU_IDX_REFRESH, 2'h0}: begin
                    next_refresh = merge(refresh_enable_reg, avs_writedata, avs_byteenable);
                end
                default: begin
                end
            endcase
        end
        if (avs_read & ~ack) begin
            case (avs_address)
                {`MCSU_IDX_UPPER, 2'h0}: next_readdata = {16'h0, upper_region_select_cfg};
                {`MCSU_IDX_LOW, 2'h0}: next_readdata = {16'h0, low_region_select_cfg};
                {`MCSU_IDX_PERIPH, 2'h0}: next_readdata = {16'h0, periph_cfg};
                {`MCSU_IDX_REFRESH, 2'h0}: next_readdata = {16'h0, refresh_enable_reg};
                {`MCSU_IDX_STATUS, 2'h0}: next_readdata = {16'h0, status};
                default: next_readdata = 32'h0;
            endcase
        end
        // The synchroniser needs a few edges to carry the pin level after release.
        next_strap_cnt = strap_cnt;
        next_strap_taken = strap_taken;
        next_strap_forced = strap_forced;
        if (!strap_taken) begin
            if (strap_cnt == `MCSU_STRAP_DELAY) begin
                next_strap_taken = 1'b1;
                next_strap_forced = ~strap_sync;
            end else begin
                next_strap_cnt = strap_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            upper_region_select_cfg <= `MCSU_UPPER_RST;
            low_region_select_cfg <= `MCSU_LOW_RST;
            periph_cfg <= `MCSU_PERIPH_RST;
            refresh_enable_reg <= `MCSU_REFRESH_RST;
            low_en <= 1'b0;
            periph_en <= 1'b0;
            ack <= 1'b0;
            avs_readdata <= 32'h0;
            strap_cnt <= 2'h0;
            strap_taken <= 1'b0;
            strap_forced <= 1'b0;
        end else begin
            upper_region_select_cfg <= next_upper;
            low_region_select_cfg <= next_low;
            periph_cfg <= next_periph;
            refresh_enable_reg <= next_refresh;
            low_en <= next_low_en;
            periph_en <= next_periph_en;
            ack <= next_ack;
            avs_readdata <= next_readdata;
            strap_cnt <= next_strap_cnt;
            strap_taken <= next_strap_taken;
            strap_forced <= next_strap_forced;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~ack;

    // ======================================================================
    // Decode of the incoming cycle.
    logic [2:0] top_lim, bot_lim, pcode;
    logic hit_upper, hit_low, hit_periph;
    logic [3:0] p_waits;

    always_comb begin
        top_lim = low_region_select_cfg[`MCSU_LIM_HI:`MCSU_LIM_LO];
        bot_lim = upper_region_select_cfg[`MCSU_LIM_HI:`MCSU_LIM_LO];
        // Region starts at zero; bits above the limit code must be clear.
        hit_low = cyc_req.mem & low_en & ~cyc_req.addr[19]
                  & ((cyc_req.addr[18:16] & ~top_lim) == 3'h0);
        hit_upper = cyc_req.mem & cyc_req.addr[19]
                    & ((cyc_req.addr[18:16] & bot_lim) == bot_lim);
        // Peripheral block of four 256-byte selects sits in I/O space.
        hit_periph = ~cyc_req.mem & periph_en & ~cyc_req.addr[10]
                     & (cyc_req.addr[19:11] == periph_cfg[`MCSU_PBASE_HI:`MCSU_PBASE_LO]);
        pcode = {periph_cfg[`MCSU_PWAIT3_BIT], periph_cfg[`MCSU_WAIT_HI:`MCSU_WAIT_LO]};
        case (pcode)
            3'h0: p_waits = 4'h0;
            3'h1: p_waits = 4'h1;
            3'h2: p_waits = 4'h2;
            3'h3: p_waits = 4'h3;
            3'h4: p_waits = 4'h5;
            3'h5: p_waits = 4'h7;
            3'h6: p_waits = 4'h9;
            default: p_waits = 4'hf;
        endcase
    end

    // ======================================================================
    // Cycle sequencer.
    mcsu_pkg::mcsu_state_t next_state;
    logic [3:0] wait_cnt, next_wait_cnt;
    logic need_ready, next_need_ready;
    mcsu_pkg::mcsu_sel_t next_sel;
    logic next_drive;
    logic ready_ok;

    always_comb begin
        next_state = state;
        next_wait_cnt = wait_cnt;
        next_need_ready = need_ready;
        next_sel = sel;
        next_drive = addr_drive_en;
        ready_ok = ready_sync | ~need_ready;
        cyc_done = 1'b0;
        case (state)
            mcsu_pkg::MCSU_IDLE: begin
                if (cyc_req.valid) begin
                    next_state = mcsu_pkg::MCSU_WAIT;
                    next_sel = '{upper_n: 1'b1, low_n: 1'b1, periph_n: 4'hf};
                    next_wait_cnt = 4'h0;
                    next_need_ready = 1'b0;
                    next_drive = 1'b1;
                    if (hit_upper) begin
                        next_sel.upper_n = 1'b0;
                        next_wait_cnt = {2'h0, upper_region_select_cfg[`MCSU_WAIT_HI:`MCSU_WAIT_LO]};
                        next_need_ready = ~upper_region_select_cfg[`MCSU_RDY_BIT];
                        next_drive = strap_forced | ~upper_region_select_cfg[`MCSU_DA_BIT];
                    end else if (hit_low) begin
                        next_sel.low_n = 1'b0;
                        next_wait_cnt = {2'h0, low_region_select_cfg[`MCSU_WAIT_HI:`MCSU_WAIT_LO]};
                        next_need_ready = ~low_region_select_cfg[`MCSU_RDY_BIT];
                        next_drive = strap_forced | ~low_region_select_cfg[`MCSU_DA_BIT];
                    end else if (hit_periph) begin
                        next_sel.periph_n[cyc_req.addr[9:8]] = 1'b0;
                        next_wait_cnt = p_waits;
                        next_need_ready = ~periph_cfg[`MCSU_RDY_BIT];
                    end
                end
            end
            mcsu_pkg::MCSU_WAIT: begin
                // Programmed waits always elapse, then ready is checked.
                if (wait_cnt != 4'h0) begin
                    next_wait_cnt = wait_cnt - 4'h1;
                end else if (ready_ok) begin
                    next_state = mcsu_pkg::MCSU_DONE;
                end
            end
            mcsu_pkg::MCSU_DONE: begin
                cyc_done = 1'b1;
                next_state = mcsu_pkg::MCSU_IDLE;
                next_sel = '{upper_n: 1'b1, low_n: 1'b1, periph_n: 4'hf};
                next_drive = 1'b0;
            end
            default: begin
                next_state = mcsu_pkg::MCSU_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= mcsu_pkg::MCSU_IDLE;
            wait_cnt <= 4'h0;
            need_ready <= 1'b0;
            sel <= '{upper_n: 1'b1, low_n: 1'b1, periph_n: 4'hf};
            addr_drive_en <= 1'b0;
        end else begin
            state <= next_state;
            wait_cnt <= next_wait_cnt;
            need_ready <= next_need_ready;
            sel <= next_sel;
            addr_drive_en <= next_drive;
        end
    end

    // ======================================================================
    // Pin sharing and pseudo-static marking.
    assign shared_pin_n = refresh_enable_reg[`MCSU_REFRESH_EN_BIT]
                          ? refresh_strobe_n : midrange_select_three_n;
    // Refresh setup beforehand is software's duty; the unit only flags the mode.
    assign pseudo_static_enable = low_en & low_region_select_cfg[`MCSU_PSE_BIT];

    // ======================================================================
    // Checks.
    logic [4:0] wait_seen;
    logic [3:0] waits_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wait_seen <= 5'h0;
            waits_q <= 4'h0;
        end else if (state == mcsu_pkg::MCSU_IDLE) begin
            wait_seen <= 5'h0;
            waits_q <= next_wait_cnt;
        end else if (state == mcsu_pkg::MCSU_WAIT) begin
            wait_seen <= wait_seen + 5'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_start_low;
        state == mcsu_pkg::MCSU_IDLE && cyc_req.valid && hit_low && !hit_upper;
    endsequence

    property p_low_follows;
        s_start_low |=> !sel.low_n ##1 !sel.low_n;
    endproperty
    a_low_follows: assert property (p_low_follows) else $error("low select missed hit");

    property p_low_enable;
        $rose(low_en) |-> $past(avs_write && avs_address == {`MCSU_IDX_LOW, 2'h0});
    endproperty
    a_low_enable: assert property (p_low_enable) else $error("low select enabled without write");

    property p_wait_count;
        cyc_done |-> wait_seen > {1'b0, waits_q};
    endproperty
    a_wait_count: assert property (p_wait_count) else $error("cycle ended before waits");

    property p_ready_needed;
        cyc_done |-> $past(ready_ok) && $past(wait_cnt) == 4'h0;
    endproperty
    a_ready_needed: assert property (p_ready_needed) else $error("cycle ended without ready");

    property p_select_in_cycle;
        !(sel.low_n && sel.upper_n) |-> state != mcsu_pkg::MCSU_IDLE;
    endproperty
    a_select_in_cycle: assert property (p_select_in_cycle) else $error("select outside cycle");

    property p_strap_drive;
        strap_forced && state == mcsu_pkg::MCSU_WAIT && !(sel.low_n && sel.upper_n)
            |-> addr_drive_en;
    endproperty
    a_strap_drive: assert property (p_strap_drive) else $error("strap did not force drive");

    property p_da_off;
        state == mcsu_pkg::MCSU_IDLE && cyc_req.valid && hit_low && !hit_upper && !strap_forced
            && low_region_select_cfg[`MCSU_DA_BIT] |=> !addr_drive_en;
    endproperty
    a_da_off: assert property (p_da_off) else $error("address driven with drive off");

    property p_bus_answer;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    property p_periph_wait;
        state == mcsu_pkg::MCSU_IDLE && cyc_req.valid && hit_periph && pcode == 3'h7
            |=> wait_cnt == 4'hf;
    endproperty
    a_periph_wait: assert property (p_periph_wait) else $error("peripheral wait code wrong");

    property p_done_releases;
        cyc_done |=> sel.upper_n && sel.low_n && sel.periph_n == 4'hf;
    endproperty
    a_done_releases: assert property (p_done_releases) else $error("select held after cycle");

endmodule

// ==== tb/mcsu_mem_model.sv ====
/*
 * Model of the memories and peripherals that sit behind the chip selects.
 * Assumes active-low selects from the unit and a ready line that the unit
 * synchronises itself; the bench sets how slowly ready is given.
 */
`timescale 1ns/10ps

module mcsu_mem_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire mcsu_pkg::mcsu_sel_t sel,
    input wire logic [4:0] ready_delay,
    output logic ext_ready
);
    // ======================================================================
    // Ready answer.
    // Not selected means not ready, but the unit's synchroniser holds a stale ready two cycles longer, which can end a cycle started right after another.
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic next_ready;
    logic any_sel;

    assign any_sel = !(sel.upper_n && sel.low_n && (&sel.periph_n));

    always_comb begin
        next_cnt = 5'h00;
        next_ready = 1'b0;
        if (any_sel) begin
            next_cnt = (cnt != ready_delay) ? cnt + 5'h01 : cnt;
            next_ready = (cnt == ready_delay);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 5'h00;
            ext_ready <= 1'b0;
        end else begin
            cnt <= next_cnt;
            ext_ready <= next_ready;
        end
    end
endmodule

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench of the memory chip-select unit.
 * Assumes the unit's package and defines header are compiled first.
 */
`timescale 1ns/10ps
`include "mcsu_defines.svh"
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end

module tb_top;
    // ======================================================================
    // Signals.
    logic clock;
    logic rst_n;
    logic [9:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    mcsu_pkg::mcsu_cyc_t cyc_req;
    logic cyc_done;
    logic ext_ready;
    logic addr_enable_strap_n;
    logic midrange_select_three_n;
    logic refresh_strobe_n;
    mcsu_pkg::mcsu_sel_t sel;
    logic addr_drive_en;
    logic pseudo_static_enable;
    logic shared_pin_n;
    logic [4:0] dly;
    logic [31:0] rd;
    logic [5:0] cs;
    logic cd;
    int ck;
    int errors;
    int comparisons;

    localparam logic [9:0] up_a = {`MCSU_IDX_UPPER, 2'b00};
    localparam logic [9:0] lo_a = {`MCSU_IDX_LOW, 2'b00};
    localparam logic [9:0] pe_a = {`MCSU_IDX_PERIPH, 2'b00};
    localparam logic [9:0] rf_a = {`MCSU_IDX_REFRESH, 2'b00};

    // ======================================================================
    // Ordinary cases: register write, then one bus cycle with ready ignored.
    typedef struct {
        logic [9:0] ra;
        logic [15:0] rv;
        logic [19:0] a;
        logic m;
        logic [5:0] es;
        int k;
    } mcsu_row_t;

    mcsu_row_t rows [0:29] = '{
        '{lo_a, 16'h0f3c, 20'h00000, 1'b1, 6'h2f, 2},
        '{lo_a, 16'h0f3d, 20'h0ffff, 1'b1, 6'h2f, 3},
        '{lo_a, 16'h0f3d, 20'h10000, 1'b1, 6'h3f, 2},
        '{lo_a, 16'h1f3e, 20'h1ffff, 1'b1, 6'h2f, 4},
        '{lo_a, 16'h1f3e, 20'h20000, 1'b1, 6'h3f, 2},
        '{lo_a, 16'h3f3f, 20'h3ffff, 1'b1, 6'h2f, 5},
        '{lo_a, 16'h3f3f, 20'h40000, 1'b1, 6'h3f, 2},
        '{lo_a, 16'h7f3c, 20'h7ffff, 1'b1, 6'h2f, 2},
        '{lo_a, 16'h7f3c, 20'h80000, 1'b1, 6'h3f, 2},
        '{up_a, 16'hf03c, 20'hf0000, 1'b1, 6'h1f, 2},
        '{up_a, 16'hf03d, 20'hfffff, 1'b1, 6'h1f, 3},
        '{up_a, 16'he03e, 20'he0000, 1'b1, 6'h1f, 4},
        '{up_a, 16'he03e, 20'hdffff, 1'b1, 6'h3f, 2},
        '{up_a, 16'hc03f, 20'hc0000, 1'b1, 6'h1f, 5},
        '{up_a, 16'hc03f, 20'hbffff, 1'b1, 6'h3f, 2},
        '{up_a, 16'h803f, 20'h80000, 1'b1, 6'h1f, 5},
        '{up_a, 16'h803c, 20'h7ffff, 1'b1, 6'h2f, 2},
        '{up_a, 16'h803c, 20'hf0000, 1'b0, 6'h3f, 2},
        '{pe_a, 16'h0074, 20'h00000, 1'b0, 6'h3e, 2},
        '{pe_a, 16'h0075, 20'h00100, 1'b0, 6'h3d, 3},
        '{pe_a, 16'h0076, 20'h00200, 1'b0, 6'h3b, 4},
        '{pe_a, 16'h0077, 20'h00300, 1'b0, 6'h37, 5},
        '{pe_a, 16'h007c, 20'h00000, 1'b0, 6'h3e, 7},
        '{pe_a, 16'h007d, 20'h00100, 1'b0, 6'h3d, 9},
        '{pe_a, 16'h007e, 20'h00200, 1'b0, 6'h3b, 11},
        '{pe_a, 16'h007f, 20'h00300, 1'b0, 6'h37, 17},
        '{pe_a, 16'h0074, 20'h00400, 1'b0, 6'h3f, 2},
        '{pe_a, 16'h00f4, 20'h00800, 1'b0, 6'h3e, 2},
        '{pe_a, 16'h00f4, 20'h007ff, 1'b0, 6'h3f, 2},
        '{pe_a, 16'h00f4, 20'h00800, 1'b1, 6'h2f, 2}
    };

    mcsu_top dut_u (
        .clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cyc_req(cyc_req), .cyc_done(cyc_done),
        .ext_ready(ext_ready), .addr_enable_strap_n(addr_enable_strap_n),
        .midrange_select_three_n(midrange_select_three_n),
        .refresh_strobe_n(refresh_strobe_n), .sel(sel), .addr_drive_en(addr_drive_en),
        .pseudo_static_enable(pseudo_static_enable), .shared_pin_n(shared_pin_n)
    );

    mcsu_mem_model mem_u (
        .clock(clock), .rst_n(rst_n), .sel(sel), .ready_delay(dly), .ext_ready(ext_ready)
    );

    // ======================================================================
    // Tasks.
    task automatic close_out();
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // The strap is held well past its capture point after release.
    task automatic do_reset(input logic strap);
        @(posedge clock);
        rst_n <= 1'b0;
        addr_enable_strap_n <= strap;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        repeat (10) @(posedge clock);
    endtask

    // Waitrequest is sampled at each rising edge; read data are taken and the
    // request is released at the very edge that finds it low.
    task automatic bus_xfer(input logic wr, input logic [9:0] a, input logic [15:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_byteenable <= 4'hf;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic run_cyc(input logic [19:0] a, input logic m);
        @(posedge clock);
        cyc_req <= {1'b1, m, a};
        @(posedge clock);
        cyc_req.valid <= 1'b0;
        #1;
        cs = sel;
        cd = addr_drive_en;
        ck = 1;
        while (cyc_done !== 1'b1 && ck < 60) begin
            @(posedge clock);
            #1;
            ck++;
        end
        @(posedge clock);
        #1;
        `CHK("idle sel", 6'h3f, sel)
    endtask

    // ======================================================================
    // Clock, watchdog and main sequence.
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial begin
        repeat (8000) @(posedge clock);
        errors++;
        close_out();
    end

    initial begin
        errors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        avs_address = 10'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
        cyc_req = '0;
        addr_enable_strap_n = 1'b1;
        midrange_select_three_n = 1'b1;
        refresh_strobe_n = 1'b0;
        dly = 5'h00;
        do_reset(1'b1);
        bus_xfer(1'b0, up_a, 16'h0000);
        `CHK("upper cfg", 32'h0000f03b, rd)
        bus_xfer(1'b0, 10'h004, 16'h0000);
        `CHK("unmapped", 32'h00000000, rd)
        run_cyc(20'h00000, 1'b1);
        `CHK("low off", 6'h3f, cs)
        run_cyc(20'hf0000, 1'b1);
        `CHK("upper sel", 6'h1f, cs)
        `CHK("upper waits", 5, ck)
        run_cyc(20'hef000, 1'b1);
        `CHK("upper miss", 6'h3f, cs)
        dly = 5'h0a;
        run_cyc(20'hfffff, 1'b1);
        `CHK("slow ready", 1'b1, (ck >= 12 && ck <= 20))
        dly = 5'h00;
        foreach (rows[i]) begin
            bus_xfer(1'b1, rows[i].ra, rows[i].rv);
            run_cyc(rows[i].a, rows[i].m);
            `CHK("sel", rows[i].es, cs)
            `CHK("waits", rows[i].k, ck)
            `CHK("drive", 1'b1, cd)
        end
        @(posedge clock);
        #1;
        `CHK("shared mid", 1'b1, shared_pin_n)
        `CHK("pseudo static off", 1'b0, pseudo_static_enable)
        bus_xfer(1'b1, rf_a, 16'h8000);
        #1;
        `CHK("shared refresh", 1'b0, shared_pin_n)
        refresh_strobe_n <= 1'b1;
        bus_xfer(1'b1, lo_a, 16'h0ffc);
        #1;
        `CHK("pseudo static", 1'b1, pseudo_static_enable)
        `CHK("shared follows", 1'b1, shared_pin_n)
        run_cyc(20'h00000, 1'b1);
        `CHK("low sel da", 6'h2f, cs)
        `CHK("drive off", 1'b0, cd)
        do_reset(1'b0);
        bus_xfer(1'b0, up_a, 16'h0000);
        `CHK("upper cfg 2", 32'h0000f03b, rd)
        run_cyc(20'h00000, 1'b1);
        `CHK("low off 2", 6'h3f, cs)
        bus_xfer(1'b1, lo_a, 16'h0ffc);
        run_cyc(20'h00000, 1'b1);
        `CHK("low sel strap", 6'h2f, cs)
        `CHK("drive forced", 1'b1, cd)
        bus_xfer(1'b0, {`MCSU_IDX_STATUS, 2'b00}, 16'h0000);
        `CHK("status", 32'h0000000a, rd)
        close_out();
    end
endmodule
